// File: verilog/dlr_regbank_defines.vh
/*
 Register offsets, field positions, reset values and writable masks of the
 dual LED driver register bank. Assumes a 6-bit register address space.
*/
`ifndef DLR_REGBANK_DEFINES_VH
`define DLR_REGBANK_DEFINES_VH

// Register offsets
`define DLR_OFF_SYSTEM_CONFIG_ONE 6'h00
`define DLR_OFF_SYSTEM_CONFIG_TWO 6'h01
`define DLR_OFF_COMM_WATCHDOG_TAP 6'h02
`define DLR_OFF_CHANNEL_FAULT_FLAGS_A 6'h03
`define DLR_OFF_CHANNEL_FAULT_FLAGS_B 6'h04
`define DLR_OFF_DEVICE_CONDITION_FLAGS 6'h05
`define DLR_OFF_THERMAL_WARNING_LIMIT 6'h06
`define DLR_OFF_SLEEP_CONTROL 6'h07
`define DLR_OFF_CH1_CURRENT_REF_LOW 6'h08
`define DLR_OFF_CH1_CURRENT_REF_HIGH 6'h09
`define DLR_OFF_CH2_CURRENT_REF_LOW 6'h0a
`define DLR_OFF_CH2_CURRENT_REF_HIGH 6'h0b
`define DLR_OFF_PWM_COUNTER_DIVIDER 6'h0c
`define DLR_OFF_CH1_DUTY_LOW 6'h0d
`define DLR_OFF_CH1_DUTY_HIGH 6'h0e
`define DLR_OFF_CH2_DUTY_LOW 6'h0f
`define DLR_OFF_CH2_DUTY_HIGH 6'h10
`define DLR_OFF_CH1_ON_TIME 6'h11
`define DLR_OFF_CH2_ON_TIME 6'h12
`define DLR_OFF_CH1_INPUT_VOLTAGE_SAMPLE 6'h13
`define DLR_OFF_CH1_STRING_VOLTAGE_SAMPLE 6'h14
`define DLR_OFF_CH1_STRING_VOLTAGE_LIT_SAMPLE 6'h15
`define DLR_OFF_CH1_STRING_VOLTAGE_DARK_SAMPLE 6'h16
`define DLR_OFF_CH2_INPUT_VOLTAGE_SAMPLE 6'h17
`define DLR_OFF_CH2_STRING_VOLTAGE_SAMPLE 6'h18
`define DLR_OFF_CH2_STRING_VOLTAGE_LIT_SAMPLE 6'h19
`define DLR_OFF_CH2_STRING_VOLTAGE_DARK_SAMPLE 6'h1a
`define DLR_OFF_DIE_TEMPERATURE_LOW 6'h1b
`define DLR_OFF_DIE_TEMPERATURE_HIGH 6'h1c
`define DLR_OFF_FIVE_VOLT_RAIL_SAMPLE 6'h1d
`define DLR_OFF_FALLBACK_CONFIG_ONE 6'h1e
`define DLR_OFF_FALLBACK_CONFIG_TWO 6'h1f
`define DLR_OFF_FALLBACK_PIN_LEVEL_LOW 6'h20
`define DLR_OFF_FALLBACK_PIN_LEVEL_HIGH 6'h21
`define DLR_OFF_FALLBACK_PIN_FILTERED_LOW 6'h22
`define DLR_OFF_FALLBACK_PIN_FILTERED_HIGH 6'h23
`define DLR_OFF_FALLBACK_CH1_CURRENT_REF_LOW 6'h24
`define DLR_OFF_FALLBACK_CH1_CURRENT_REF_HIGH 6'h25
`define DLR_OFF_FALLBACK_CH2_CURRENT_REF_LOW 6'h26
`define DLR_OFF_FALLBACK_CH2_CURRENT_REF_HIGH 6'h27
`define DLR_OFF_FALLBACK_CH1_DUTY_LOW 6'h28
`define DLR_OFF_FALLBACK_CH1_DUTY_HIGH 6'h29
`define DLR_OFF_FALLBACK_CH2_DUTY_LOW 6'h2a
`define DLR_OFF_FALLBACK_CH2_DUTY_HIGH 6'h2b
`define DLR_OFF_FALLBACK_CH1_ON_TIME 6'h2c
`define DLR_OFF_FALLBACK_CH2_ON_TIME 6'h2d

// Fields of system_config_one
`define DLR_BIT_CH1_ENABLE 0
`define DLR_BIT_CH1_INTERNAL_PWM 1
`define DLR_BIT_CH2_ENABLE 2
`define DLR_BIT_CH2_INTERNAL_PWM 3
`define DLR_BIT_COMM_WATCHDOG_ENABLE 4
`define DLR_BIT_SOFTWARE_FALLBACK_REQUEST 5
`define DLR_BIT_INTERNAL_PWM_PHASE_SELECT 6
`define DLR_BIT_FAULT_OUTPUT_CLEAR 7

// Reset values
`define DLR_RST_ZERO 8'h00
`define DLR_RST_SYSTEM_CONFIG_ONE 8'h10
`define DLR_RST_COMM_WATCHDOG_TAP 8'h08
`define DLR_RST_THERMAL_WARNING_LIMIT 8'h8a
`define DLR_RST_PWM_COUNTER_DIVIDER 8'h04
`define DLR_RST_ON_TIME 8'h07

// Writable masks, reserved bits are held at zero
`define DLR_MSK_NONE 8'h00
`define DLR_MSK_2B 8'h03
`define DLR_MSK_3B 8'h07
`define DLR_MSK_4B 8'h0f
`define DLR_MSK_6B 8'h3f
`define DLR_MSK_8B 8'hff

`endif

// File: verilog/dlr_reset_sync.v
/*
 Reset release synchroniser for the register bank.
 Assumes an active-low asynchronous reset; assertion is immediate,
 release reaches the design after two clock edges.
*/
`timescale 1ns/1ps
module dlr_reset_sync (
    // Clock and raw reset
    input wire sys_clk,
    input wire arst_n,
    // Synchronised reset
    output wire rst_n
);
    reg meta_reg;
    reg sync_reg;

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= 1'b1;
            sync_reg <= meta_reg;
        end
    end

    assign rst_n = sync_reg;
endmodule // dlr_reset_sync

// File: verilog/dlr_field_reg.v
/*
 One host-writable 8-bit register with reset value and writable mask.
 Assumes a synchronised active-low reset; bits outside the mask stay zero.
*/
`timescale 1ns/1ps
module dlr_field_reg #(
    parameter [7:0] RST_VAL = 8'h00,
    parameter [7:0] MASK = 8'hff
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Write strobe and data
    input wire wr_en,
    input wire [7:0] wdata,
    // Stored value
    output wire [7:0] q
);
    reg [7:0] q_reg;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg <= RST_VAL & MASK;
        end else if (wr_en) begin
            q_reg <= wdata & MASK;
        end
    end

    assign q = q_reg;
endmodule // dlr_field_reg

// File: verilog/dlr_regbank.v
/*
 Register array of the dual LED driver: configuration, fallback set and
 readback of status and sample values, on a plain byte register port.
 Assumes the serial front end presents one-cycle read and write strobes
 with a stable address and data, and that status and sample inputs are
 synchronous to sys_clk.
*/
// Behaviour
// - 8-bit registers, 6-bit address, 0x00..0x3F
// - Reset loads every register default value
// - Unlisted address reads return zero
// - Registers read/write unless described otherwise
// - Fault clear bit write-only, reads zero
// - Comm failure sets fallback; zero write clears
// - Watchdog enable resets to one
// - Phase bit zero offset, one aligned
`timescale 1ns/1ps
`include "dlr_regbank_defines.vh"
module dlr_regbank (
    // Clock and reset
    input wire sys_clk,
    input wire arst_n,
    // Register port
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [5:0] reg_addr,
    input wire [7:0] reg_wdata,
    output wire [7:0] reg_rdata,
    output wire reg_rd_valid,
    // Events
    input wire comm_fail_evt,
    // Status inputs
    input wire [7:0] channel_fault_flags_a,
    input wire [7:0] channel_fault_flags_b,
    input wire [7:0] device_condition_flags,
    // Sample inputs
    input wire [7:0] ch1_input_voltage,
    input wire [7:0] ch1_string_voltage,
    input wire [7:0] ch1_string_voltage_lit,
    input wire [7:0] ch1_string_voltage_dark,
    input wire [7:0] ch2_input_voltage,
    input wire [7:0] ch2_string_voltage,
    input wire [7:0] ch2_string_voltage_lit,
    input wire [7:0] ch2_string_voltage_dark,
    input wire [9:0] die_temperature,
    input wire [7:0] five_volt_rail,
    input wire [9:0] fallback_pin_level,
    input wire [9:0] fallback_pin_filtered,
    // System configuration
    output wire ch1_enable,
    output wire ch1_internal_pwm,
    output wire ch2_enable,
    output wire ch2_internal_pwm,
    output wire comm_watchdog_enable,
    output wire software_fallback_request,
    output wire internal_pwm_phase_select,
    output wire internal_pwm_offset_half,
    output wire fault_output_clear,
    output wire [7:0] system_config_two,
    output wire [3:0] comm_watchdog_tap,
    output wire [7:0] thermal_warning_limit,
    output wire [1:0] sleep_control,
    // Channel settings
    output wire [9:0] ch1_analog_current_reference,
    output wire [9:0] ch2_analog_current_reference,
    output wire [2:0] pwm_counter_divider,
    output wire [9:0] ch1_duty,
    output wire [9:0] ch2_duty,
    output wire [5:0] ch1_on_time,
    output wire [5:0] ch2_on_time,
    // Fallback settings
    output wire [7:0] fallback_config_one,
    output wire [7:0] fallback_config_two,
    output wire [9:0] fallback_ch1_analog_current_reference,
    output wire [9:0] fallback_ch2_analog_current_reference,
    output wire [9:0] fallback_ch1_duty,
    output wire [9:0] fallback_ch2_duty,
    output wire [5:0] fallback_ch1_on_time,
    output wire [5:0] fallback_ch2_on_time
);
    // {reset value, writable mask} of each generic read/write register
    function [15:0] reg_spec;
        input integer a;
        begin
            case (a)
                `DLR_OFF_SYSTEM_CONFIG_TWO:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_8B};
                `DLR_OFF_COMM_WATCHDOG_TAP:
                    reg_spec = {`DLR_RST_COMM_WATCHDOG_TAP, `DLR_MSK_4B};
                `DLR_OFF_THERMAL_WARNING_LIMIT:
                    reg_spec = {`DLR_RST_THERMAL_WARNING_LIMIT, `DLR_MSK_8B};
                `DLR_OFF_SLEEP_CONTROL:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_2B};
                `DLR_OFF_CH1_CURRENT_REF_LOW:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_2B};
                `DLR_OFF_CH1_CURRENT_REF_HIGH:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_8B};
                `DLR_OFF_CH2_CURRENT_REF_LOW:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_2B};
                `DLR_OFF_CH2_CURRENT_REF_HIGH:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_8B};
                `DLR_OFF_PWM_COUNTER_DIVIDER:
                    reg_spec = {`DLR_RST_PWM_COUNTER_DIVIDER, `DLR_MSK_3B};
                `DLR_OFF_CH1_DUTY_LOW:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_8B};
                `DLR_OFF_CH1_DUTY_HIGH:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_2B};
                `DLR_OFF_CH2_DUTY_LOW:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_8B};
                `DLR_OFF_CH2_DUTY_HIGH:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_2B};
                `DLR_OFF_CH1_ON_TIME:
                    reg_spec = {`DLR_RST_ON_TIME, `DLR_MSK_6B};
                `DLR_OFF_CH2_ON_TIME:
                    reg_spec = {`DLR_RST_ON_TIME, `DLR_MSK_6B};
                `DLR_OFF_FALLBACK_CONFIG_ONE:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_8B};
                `DLR_OFF_FALLBACK_CONFIG_TWO:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_8B};
                `DLR_OFF_FALLBACK_CH1_CURRENT_REF_LOW:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_2B};
                `DLR_OFF_FALLBACK_CH1_CURRENT_REF_HIGH:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_8B};
                `DLR_OFF_FALLBACK_CH2_CURRENT_REF_LOW:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_2B};
                `DLR_OFF_FALLBACK_CH2_CURRENT_REF_HIGH:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_8B};
                `DLR_OFF_FALLBACK_CH1_DUTY_LOW:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_8B};
                `DLR_OFF_FALLBACK_CH1_DUTY_HIGH:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_2B};
                `DLR_OFF_FALLBACK_CH2_DUTY_LOW:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_8B};
                `DLR_OFF_FALLBACK_CH2_DUTY_HIGH:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_2B};
                `DLR_OFF_FALLBACK_CH1_ON_TIME:
                    reg_spec = {`DLR_RST_ON_TIME, `DLR_MSK_6B};
                `DLR_OFF_FALLBACK_CH2_ON_TIME:
                    reg_spec = {`DLR_RST_ON_TIME, `DLR_MSK_6B};
                default:
                    reg_spec = {`DLR_RST_ZERO, `DLR_MSK_NONE};
            endcase
        end
    endfunction

    wire rst_n;
    wire [7:0] rw_q [0:63];
    wire cfg1_wr;
    reg [6:0] cfg1_reg;
    reg [6:0] cfg1_next;
    reg fault_clear_reg;
    reg offset_half_reg;
    localparam [7:0] CFG1_RST = `DLR_RST_SYSTEM_CONFIG_ONE;
    reg [7:0] rdata_reg;
    reg [7:0] rdata_next;
    reg rd_valid_reg;

    dlr_reset_sync u_reset_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .rst_n(rst_n)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 64; gi = gi + 1) begin : g_rw
            localparam [15:0] SPEC = reg_spec(gi);
            if (SPEC[7:0] != 8'h00) begin : g_reg
                wire hit;
                assign hit = reg_wr_en && ({26'd0, reg_addr} == gi);
                dlr_field_reg #(
                    .RST_VAL(SPEC[15:8]),
                    .MASK(SPEC[7:0])
                ) u_reg (
                    .sys_clk(sys_clk),
                    .rst_n(rst_n),
                    .wr_en(hit),
                    .wdata(reg_wdata),
                    .q(rw_q[gi])
                );
            end else begin : g_none
                assign rw_q[gi] = 8'h00;
            end
        end
    endgenerate

    // System configuration one is kept here: hardware also sets bit 5
    assign cfg1_wr = reg_wr_en && (reg_addr == `DLR_OFF_SYSTEM_CONFIG_ONE);

    always @* begin
        cfg1_next = cfg1_reg;
        if (cfg1_wr) begin
            cfg1_next = reg_wdata[6:0];
        end
        if (comm_fail_evt) begin
            cfg1_next[`DLR_BIT_SOFTWARE_FALLBACK_REQUEST] = 1'b1;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg1_reg <= CFG1_RST[6:0];
            offset_half_reg <= ~CFG1_RST[`DLR_BIT_INTERNAL_PWM_PHASE_SELECT];
            fault_clear_reg <= 1'b0;
        end else begin
            cfg1_reg <= cfg1_next;
            // own flop, so the output is registered
            offset_half_reg <= ~cfg1_next[`DLR_BIT_INTERNAL_PWM_PHASE_SELECT];
            fault_clear_reg <= cfg1_wr & reg_wdata[`DLR_BIT_FAULT_OUTPUT_CLEAR];
        end
    end

    // Read multiplexer; sample registers show live inputs, no capture
    always @* begin
        case (reg_addr)
            `DLR_OFF_SYSTEM_CONFIG_ONE:
                rdata_next = {1'b0, cfg1_reg};
            `DLR_OFF_CHANNEL_FAULT_FLAGS_A:
                rdata_next = channel_fault_flags_a;
            `DLR_OFF_CHANNEL_FAULT_FLAGS_B:
                rdata_next = channel_fault_flags_b & `DLR_MSK_6B;
            `DLR_OFF_DEVICE_CONDITION_FLAGS:
                rdata_next = device_condition_flags;
            `DLR_OFF_CH1_INPUT_VOLTAGE_SAMPLE:
                rdata_next = ch1_input_voltage;
            `DLR_OFF_CH1_STRING_VOLTAGE_SAMPLE:
                rdata_next = ch1_string_voltage;
            `DLR_OFF_CH1_STRING_VOLTAGE_LIT_SAMPLE:
                rdata_next = ch1_string_voltage_lit;
            `DLR_OFF_CH1_STRING_VOLTAGE_DARK_SAMPLE:
                rdata_next = ch1_string_voltage_dark;
            `DLR_OFF_CH2_INPUT_VOLTAGE_SAMPLE:
                rdata_next = ch2_input_voltage;
            `DLR_OFF_CH2_STRING_VOLTAGE_SAMPLE:
                rdata_next = ch2_string_voltage;
            `DLR_OFF_CH2_STRING_VOLTAGE_LIT_SAMPLE:
                rdata_next = ch2_string_voltage_lit;
            `DLR_OFF_CH2_STRING_VOLTAGE_DARK_SAMPLE:
                rdata_next = ch2_string_voltage_dark;
            `DLR_OFF_DIE_TEMPERATURE_LOW:
                rdata_next = {6'h00, die_temperature[1:0]};
            `DLR_OFF_DIE_TEMPERATURE_HIGH:
                rdata_next = die_temperature[9:2];
            `DLR_OFF_FIVE_VOLT_RAIL_SAMPLE:
                rdata_next = five_volt_rail;
            `DLR_OFF_FALLBACK_PIN_LEVEL_LOW:
                rdata_next = {6'h00, fallback_pin_level[1:0]};
            `DLR_OFF_FALLBACK_PIN_LEVEL_HIGH:
                rdata_next = fallback_pin_level[9:2];
            `DLR_OFF_FALLBACK_PIN_FILTERED_LOW:
                rdata_next = {6'h00, fallback_pin_filtered[1:0]};
            `DLR_OFF_FALLBACK_PIN_FILTERED_HIGH:
                rdata_next = fallback_pin_filtered[9:2];
            default:
                rdata_next = rw_q[reg_addr];
        endcase
    end

    // Read data holds until the next read so the serializer may take it late
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= reg_rd_en;
            if (reg_rd_en) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rd_valid = rd_valid_reg;

    assign ch1_enable = cfg1_reg[`DLR_BIT_CH1_ENABLE];
    assign ch1_internal_pwm = cfg1_reg[`DLR_BIT_CH1_INTERNAL_PWM];
    assign ch2_enable = cfg1_reg[`DLR_BIT_CH2_ENABLE];
    assign ch2_internal_pwm = cfg1_reg[`DLR_BIT_CH2_INTERNAL_PWM];
    assign comm_watchdog_enable = cfg1_reg[`DLR_BIT_COMM_WATCHDOG_ENABLE];
    assign software_fallback_request = cfg1_reg[`DLR_BIT_SOFTWARE_FALLBACK_REQUEST];
    assign internal_pwm_phase_select = cfg1_reg[`DLR_BIT_INTERNAL_PWM_PHASE_SELECT];
    assign internal_pwm_offset_half = offset_half_reg;
    assign fault_output_clear = fault_clear_reg;

    assign system_config_two = rw_q[`DLR_OFF_SYSTEM_CONFIG_TWO];
    assign comm_watchdog_tap = rw_q[`DLR_OFF_COMM_WATCHDOG_TAP][3:0];
    assign thermal_warning_limit = rw_q[`DLR_OFF_THERMAL_WARNING_LIMIT];
    assign sleep_control = rw_q[`DLR_OFF_SLEEP_CONTROL][1:0];
    assign pwm_counter_divider = rw_q[`DLR_OFF_PWM_COUNTER_DIVIDER][2:0];
    assign ch1_on_time = rw_q[`DLR_OFF_CH1_ON_TIME][5:0];
    assign ch2_on_time = rw_q[`DLR_OFF_CH2_ON_TIME][5:0];

    // reference low register gives bits 1:0
    assign ch1_analog_current_reference = {rw_q[`DLR_OFF_CH1_CURRENT_REF_HIGH],
                                           rw_q[`DLR_OFF_CH1_CURRENT_REF_LOW][1:0]};
    assign ch2_analog_current_reference = {rw_q[`DLR_OFF_CH2_CURRENT_REF_HIGH],
                                           rw_q[`DLR_OFF_CH2_CURRENT_REF_LOW][1:0]};
    // duty low register gives bits 7:0
    assign ch1_duty = {rw_q[`DLR_OFF_CH1_DUTY_HIGH][1:0], rw_q[`DLR_OFF_CH1_DUTY_LOW]};
    assign ch2_duty = {rw_q[`DLR_OFF_CH2_DUTY_HIGH][1:0], rw_q[`DLR_OFF_CH2_DUTY_LOW]};

    assign fallback_config_one = rw_q[`DLR_OFF_FALLBACK_CONFIG_ONE];
    assign fallback_config_two = rw_q[`DLR_OFF_FALLBACK_CONFIG_TWO];
    assign fallback_ch1_analog_current_reference = {rw_q[`DLR_OFF_FALLBACK_CH1_CURRENT_REF_HIGH],
                                                    rw_q[`DLR_OFF_FALLBACK_CH1_CURRENT_REF_LOW][1:0]};
    assign fallback_ch2_analog_current_reference = {rw_q[`DLR_OFF_FALLBACK_CH2_CURRENT_REF_HIGH],
                                                    rw_q[`DLR_OFF_FALLBACK_CH2_CURRENT_REF_LOW][1:0]};
    assign fallback_ch1_duty = {rw_q[`DLR_OFF_FALLBACK_CH1_DUTY_HIGH][1:0],
                                rw_q[`DLR_OFF_FALLBACK_CH1_DUTY_LOW]};
    assign fallback_ch2_duty = {rw_q[`DLR_OFF_FALLBACK_CH2_DUTY_HIGH][1:0],
                                rw_q[`DLR_OFF_FALLBACK_CH2_DUTY_LOW]};
    assign fallback_ch1_on_time = rw_q[`DLR_OFF_FALLBACK_CH1_ON_TIME][5:0];
    assign fallback_ch2_on_time = rw_q[`DLR_OFF_FALLBACK_CH2_ON_TIME][5:0];
endmodule // dlr_regbank

// File: verif/dlr_regbank_asserts.sv
/*
 Checker for the register bank: port timing, fault-clear pulse, fallback bit.
 Assumes it is bound to dlr_regbank and sees only its ports.
*/
`timescale 1ns/1ps
module dlr_regbank_asserts (
    // Clock and reset
    input wire sys_clk,
    input wire arst_n,
    // Register port
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [5:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire reg_rd_valid,
    // Event and configuration
    input wire comm_fail_evt,
    input wire comm_watchdog_enable,
    input wire software_fallback_request,
    input wire internal_pwm_phase_select,
    input wire internal_pwm_offset_half,
    input wire fault_output_clear,
    input wire [9:0] ch1_duty
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    a_valid_follows_read: assert property (reg_rd_valid == $past(reg_rd_en))
        else $error("read valid not one cycle after read strobe");
    a_rdata_holds: assert property (!reg_rd_en |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_unlisted_reads_zero: assert property (reg_rd_en && reg_addr >= 6'h2e |=> reg_rdata == 8'h00)
        else $error("unlisted address read not zero");
    a_clear_bit_reads_zero: assert property (reg_rd_en && reg_addr == 6'h00 |=> !reg_rdata[7])
        else $error("fault clear bit read back as one");
    a_fault_clear_pulse: assert property (reg_wr_en && reg_addr == 6'h00 && reg_wdata[7]
        |=> fault_output_clear ##1 !fault_output_clear)
        else $error("fault clear not a one-cycle pulse");
    a_fallback_sets: assert property (comm_fail_evt |=> software_fallback_request)
        else $error("comm failure did not set fallback");
    a_fallback_holds: assert property (software_fallback_request && !(reg_wr_en && reg_addr == 6'h00
        && !reg_wdata[5]) |=> software_fallback_request)
        else $error("fallback cleared without a zero write");
    a_watchdog_off_write: assert property (reg_wr_en && reg_addr == 6'h00 && !reg_wdata[4]
        |=> !comm_watchdog_enable)
        else $error("watchdog stayed on after zero write");
    a_phase_offset_inverse: assert property (internal_pwm_offset_half != internal_pwm_phase_select)
        else $error("half offset does not invert phase bit");
    a_duty_low_byte: assert property (reg_wr_en && reg_addr == 6'h0d |=> ch1_duty[7:0] == $past(reg_wdata))
        else $error("duty low byte not taken from low register");
endmodule // dlr_regbank_asserts

bind dlr_regbank dlr_regbank_asserts u_asserts (.sys_clk(sys_clk), .arst_n(arst_n), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .comm_fail_evt(comm_fail_evt), .comm_watchdog_enable(comm_watchdog_enable),
    .software_fallback_request(software_fallback_request), .internal_pwm_phase_select(internal_pwm_phase_select),
    .internal_pwm_offset_half(internal_pwm_offset_half), .fault_output_clear(fault_output_clear),
    .ch1_duty(ch1_duty));

// File: verif/dlr_host_model.sv
/*
 Register-port master standing in for the serial front end.
 Assumes op and idle are called at falling clock edges.
*/
`timescale 1ns/1ps
module dlr_host_model (
    // Clock
    input wire sys_clk,
    // Register port
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [5:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire reg_rd_valid
);
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 6'h2e;
        reg_wdata = 8'h00;
    end
    // any of the 64 addresses; callers keep reserved bits zero
    // Strobes stay up between calls so back-to-back transfers never glitch
    task op(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d,
            output logic [7:0] q, output logic v);
        reg_wr_en = w;
        reg_rd_en = r;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        q = reg_rdata;
        v = reg_rd_valid;
    endtask
    // Released lines flip so a stale address never looks live
    task idle();
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
        @(negedge sys_clk);
    endtask
endmodule // dlr_host_model

// File: verif/dlr_regbank_bench.sv
/*
 Self-checking bench for the register bank: sweeps, row writes, pulses, reset.
 Assumes the host model drives the register port at falling edges.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module dlr_regbank_bench;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic comm_fail_evt = 1'b0;
    logic [7:0] pat = 8'h5a;
    wire reg_wr_en, reg_rd_en, reg_rd_valid, cwe, sfr, pps, poh, foc;
    wire [5:0] reg_addr;
    wire [7:0] reg_wdata, reg_rdata;
    wire [9:0] ch1_duty, ch1_iref;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [7:0] mirror [64];
    logic [7:0] rq;
    logic rv;
    // Writable registers: address, reset value, pattern with reserved bits zero
    logic [23:0] rows [28] = '{24'h00106f, 24'h0100a5, 24'h020805, 24'h068a5c, 24'h070002, 24'h080003,
        24'h0900c3, 24'h0a0001, 24'h0b007e, 24'h0c0403, 24'h0d00e1, 24'h0e0002, 24'h0f0096, 24'h100001,
        24'h11072a, 24'h120715, 24'h1e00f0, 24'h1f000f, 24'h240002, 24'h250099, 24'h260001, 24'h270066,
        24'h2800b4, 24'h290003, 24'h2a004b, 24'h2b0002, 24'h2c073f, 24'h2d0720};

    always #4 sys_clk = ~sys_clk;

    dlr_host_model host (.sys_clk(sys_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));

    dlr_regbank dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .comm_fail_evt(comm_fail_evt), .channel_fault_flags_a(pat ^ 8'h03), .channel_fault_flags_b(pat ^ 8'h04),
        .device_condition_flags(pat ^ 8'h05), .ch1_input_voltage(pat ^ 8'h13), .ch1_string_voltage(pat ^ 8'h14),
        .ch1_string_voltage_lit(pat ^ 8'h15), .ch1_string_voltage_dark(pat ^ 8'h16),
        .ch2_input_voltage(pat ^ 8'h17), .ch2_string_voltage(pat ^ 8'h18), .ch2_string_voltage_lit(pat ^ 8'h19),
        .ch2_string_voltage_dark(pat ^ 8'h1a), .die_temperature({pat ^ 8'h1c, pat[1:0]}),
        .five_volt_rail(pat ^ 8'h1d), .fallback_pin_level({pat ^ 8'h21, pat[1:0]}),
        .fallback_pin_filtered({pat ^ 8'h23, ~pat[1:0]}), .ch1_enable(), .ch1_internal_pwm(), .ch2_enable(),
        .ch2_internal_pwm(), .comm_watchdog_enable(cwe), .software_fallback_request(sfr),
        .internal_pwm_phase_select(pps), .internal_pwm_offset_half(poh), .fault_output_clear(foc),
        .system_config_two(), .comm_watchdog_tap(), .thermal_warning_limit(), .sleep_control(),
        .ch1_analog_current_reference(ch1_iref), .ch2_analog_current_reference(), .pwm_counter_divider(),
        .ch1_duty(ch1_duty), .ch2_duty(), .ch1_on_time(), .ch2_on_time(), .fallback_config_one(),
        .fallback_config_two(), .fallback_ch1_analog_current_reference(),
        .fallback_ch2_analog_current_reference(), .fallback_ch1_duty(), .fallback_ch2_duty(),
        .fallback_ch1_on_time(), .fallback_ch2_on_time());

    function automatic logic [7:0] exp_rd(input logic [5:0] a);
        if (a inside {[6'h03:6'h05], [6'h13:6'h1d], [6'h20:6'h23]}) begin
            case (a)
                6'h04: return (pat ^ 8'h04) & 8'h3f;
                6'h1b, 6'h20: return {6'h00, pat[1:0]};
                6'h22: return {6'h00, ~pat[1:0]};
                default: return pat ^ {2'h0, a};
            endcase
        end
        return mirror[a];
    endfunction

    task automatic rd(input logic [5:0] a);
        logic [7:0] e;
        e = exp_rd(a);
        host.op(1'b0, 1'b1, a, 8'h00, rq, rv);
        `CHK(rv, 1'b1)
        `CHK(rq, e)
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        host.op(1'b1, 1'b0, a, d, rq, rv);
    endtask

    task automatic sweep();
        for (int a = 0; a < 64; a++) rd(a[5:0]);
        host.idle();
    endtask

    task automatic load_defaults();
        foreach (mirror[i]) mirror[i] = 8'h00;
        foreach (rows[i]) mirror[rows[i][21:16]] = rows[i][15:8];
    endtask

    task close_out();
        if (miscompares == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // A hang costs a mismatch; the full run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            close_out();
        end
    end

    initial begin
        load_defaults();
        repeat (6) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        `CHK(cwe, 1'b1)
        `CHK(poh, 1'b1)
        sweep();
        foreach (rows[i]) begin
            wr(rows[i][21:16], rows[i][7:0]);
            mirror[rows[i][21:16]] = rows[i][7:0];
        end
        host.idle();
        pat = 8'ha5;
        sweep();
        `CHK(ch1_duty, {mirror[6'h0e][1:0], mirror[6'h0d]})
        `CHK(ch1_iref, {mirror[6'h09], mirror[6'h08][1:0]})
        `CHK(sfr, 1'b1)
        `CHK({cwe, pps, poh}, 3'b010)
        wr(6'h00, 8'h80);
        `CHK(foc, 1'b1)
        `CHK({sfr, cwe, poh}, 3'b001)
        host.idle();
        `CHK(foc, 1'b0)
        mirror[6'h00] = 8'h00;
        rd(6'h00);
        // Event and clearing write in one cycle: the event wins
        comm_fail_evt = 1'b1;
        wr(6'h00, 8'h00);
        comm_fail_evt = 1'b0;
        `CHK(sfr, 1'b1)
        wr(6'h00, 8'h10);
        `CHK({sfr, cwe}, 2'b01)
        // Read and write together return the old value
        host.op(1'b1, 1'b1, 6'h0d, 8'h3c, rq, rv);
        `CHK(rq, mirror[6'h0d])
        host.idle();
        arst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        load_defaults();
        sweep();
        close_out();
    end
endmodule // dlr_regbank_bench
